// [rtl/synth_prog_pkg.sv]
// shared constants of the serial programming port of the synthesizer
// assumes: imported whole by the top module and by the testbench
package synth_prog_pkg;
    // ****************************************
    // serial word layout
    // ****************************************
    localparam int SHIFT_BITS = 22;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_BITS = 2;
    localparam int CTRL_COUNT = 3;
    localparam logic [1:0] ADDR_REF = 2'h0;
    localparam logic [1:0] ADDR_MAIN = 2'h1;
    localparam logic [1:0] ADDR_FUNC = 2'h2;
    localparam logic [21:0] CTRL_RESET = 22'h000000;
    // ****************************************
    // field positions inside the words
    // ****************************************
    localparam int PRESC_BIT = 21;
    localparam int FA_OVR_LSB = 2;
    localparam int FAST_MODE_BIT = 6;
    localparam int STAT_SEL_LSB = 7;
    localparam int SOFT_PWDN_BIT = 0;
    // ****************************************
    // fast-acquire override and status selections
    // ****************************************
    localparam logic [1:0] FA_NORMAL = 2'h0;
    localparam logic [1:0] FA_FORCE_Z = 2'h1;
    localparam logic [1:0] FA_FORCE_LOW = 2'h2;
    localparam logic [1:0] FA_FORCE_HIGH = 2'h3;
    localparam logic [2:0] STAT_LOW = 3'h0;
    localparam logic [2:0] STAT_DIG_LD = 3'h1;
    localparam logic [2:0] STAT_ANA_LD = 3'h2;
    localparam logic [2:0] STAT_REF_CNT = 3'h3;
    localparam logic [2:0] STAT_MAIN_CNT = 3'h4;
    // ****************************************
    // apb register map
    // ****************************************
    localparam logic [11:0] OFF_CTRL_REF = 12'h000;
    localparam logic [11:0] OFF_CTRL_MAIN = 12'h004;
    localparam logic [11:0] OFF_CTRL_FUNC = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_CONFIG = 12'h010;
    localparam logic [31:0] CONFIG_RESET = 32'h00000000;
endpackage

// [rtl/synth_serial_program_port.sv]
// serial programming port, control registers and pin logic of the synthesizer
// assumes: host stops serial_clk before raising load_strobe; apb on pclk
//
// What this block does
// RULE1 - each rising serial clock edge shifts serial data into a 22-bit register
// RULE2 - the host sends every programming word most significant bit first
// RULE3 - the last two bits shifted in are the address of the target register
// RULE4 - load strobe rising copies the whole shift register into the addressed register
// RULE5 - chip enable low puts the device into its powered-down state
// RULE6 - fast-acquire pin drives low in fast-acquire mode, else high impedance
// RULE7 - two time-out counter bits can force that pin to high impedance, low or high
// RULE8 - status pin selects digital lock, open-drain analog lock or a counter output
// RULE9 - prescaler ratio is selectable between 32/33 and 16/17
// RULE10 - control registers change only on the load strobe, never while shifting
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module synth_serial_program_port
    import synth_prog_pkg::*;
#(
    parameter int WORD_BITS = SHIFT_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic lock_detect_dig,
    input wire logic lock_detect_ana,
    input wire logic ref_counter_out,
    input wire logic main_counter_out,
    output logic fast_acquire_out,
    output logic fast_acquire_oen_n,
    output logic multiplexed_status_out,
    output logic multiplexed_status_oen_n,
    output logic powered_down,
    output logic prescaler_32
);
    if (WORD_BITS != SHIFT_BITS) begin : g_bad_width
        $error("word width must match the fixed field layout");
    end

    // ****************************************
    // link domain: shift register on serial_clk
    // ****************************************
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] shift_d;
    logic shift_armed_q;
    assign shift_d = {shift_q[WORD_BITS-2:0], serial_data}; // RULE1 RULE2

    // data pin is sampled by its own clock, so it needs no synchroniser here
    always_ff @(posedge serial_clk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= '0;
            shift_armed_q <= 1'b0;
        end else begin
            shift_q <= shift_d; // RULE1
            shift_armed_q <= 1'b1; // first link edge has no earlier bit to compare
        end
    end

    // ****************************************
    // pin synchronisers into pclk
    // ****************************************
    logic [5:0] pins_s1_q;
    logic [5:0] pins_s2_q;
    logic le_s3_q;
    wire [5:0] pins_raw = {main_counter_out, ref_counter_out, lock_detect_ana,
                           lock_detect_dig, chip_enable, load_strobe};
    wire le_sync = pins_s2_q[0];
    wire ce_sync = pins_s2_q[1];
    wire ld_dig_sync = pins_s2_q[2];
    wire ld_ana_sync = pins_s2_q[3];
    wire ref_sync = pins_s2_q[4];
    wire main_sync = pins_s2_q[5];
    wire le_rise = le_sync & ~le_s3_q;

    // two flops per pin; the third flop on the strobe only feeds the edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_s1_q <= 6'h00;
            pins_s2_q <= 6'h00;
            le_s3_q <= 1'b0;
        end else begin
            pins_s1_q <= pins_raw;
            pins_s2_q <= pins_s1_q;
            le_s3_q <= le_sync;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // the shift word is quasi-static once serial_clk stops, so it is taken
    // directly on the synchronised strobe edge; a host clocking during the
    // strobe would corrupt the load
    logic [WORD_BITS-1:0] ctrl_q [CTRL_COUNT];
    logic [7:0] load_count_q;
    logic [1:0] last_addr_q;
    wire [1:0] load_addr = shift_q[ADDR_LSB +: ADDR_BITS]; // RULE3
    wire load_ok = le_rise && (load_addr < 2'(CTRL_COUNT)); // RULE3

    // address three is not a register and is dropped silently
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CTRL_COUNT; i++) begin
                ctrl_q[i] <= CTRL_RESET;
            end
            load_count_q <= 8'h00;
            last_addr_q <= 2'h0;
        end else if (load_ok) begin
            ctrl_q[load_addr] <= shift_q; // RULE4 RULE10
            load_count_q <= load_count_q + 8'h01;
            last_addr_q <= load_addr;
        end
    end

    // ****************************************
    // field decode
    // ****************************************
    logic [31:0] config_q;
    wire [WORD_BITS-1:0] func_word = ctrl_q[ADDR_FUNC];
    wire [1:0] fa_ovr = func_word[FA_OVR_LSB +: 2];
    wire fast_mode = func_word[FAST_MODE_BIT];
    wire [2:0] stat_sel = func_word[STAT_SEL_LSB +: 3];
    wire presc_d = ctrl_q[ADDR_MAIN][PRESC_BIT]; // RULE9
    wire pwdn_d = ~ce_sync | config_q[SOFT_PWDN_BIT]; // RULE5

    // fast-acquire pin: returns {level, enable_n}
    function automatic logic [1:0] fa_drive(input logic [1:0] ovr, input logic mode);
        logic [1:0] r;
        r = 2'b01;
        if (ovr == FA_FORCE_LOW) begin
            r = 2'b00;
        end else if (ovr == FA_FORCE_HIGH) begin
            r = 2'b10;
        end else if (ovr == FA_NORMAL && mode) begin
            r = 2'b00;
        end
        return r;
    endfunction

    wire [1:0] fa_d = fa_drive(fa_ovr, fast_mode); // RULE6 RULE7

    // status pin selection; analog lock is open-drain so it only ever pulls low
    wire stat_oen_d = (stat_sel == STAT_ANA_LD) ? ld_ana_sync : 1'b0; // RULE8
    wire stat_d = (stat_sel == STAT_DIG_LD) ? ld_dig_sync :
                  (stat_sel == STAT_REF_CNT) ? ref_sync :
                  (stat_sel == STAT_MAIN_CNT) ? main_sync : 1'b0; // RULE8

    // ****************************************
    // pin output flops
    // ****************************************
    // every pin is registered, costing one pclk of latency on each path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_acquire_out <= 1'b0;
            fast_acquire_oen_n <= 1'b1;
            multiplexed_status_out <= 1'b0;
            multiplexed_status_oen_n <= 1'b0;
            powered_down <= 1'b1;
            prescaler_32 <= 1'b0;
        end else begin
            fast_acquire_out <= fa_d[1]; // RULE6 RULE7
            fast_acquire_oen_n <= fa_d[0]; // RULE6 RULE7
            multiplexed_status_out <= stat_d; // RULE8
            multiplexed_status_oen_n <= stat_oen_d; // RULE8
            powered_down <= pwdn_d; // RULE5
            prescaler_32 <= presc_d; // RULE9
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    // one wait state: pready is a flop, so the answer comes in the second
    // access cycle; this keeps every output straight from a register
    wire access = psel & penable & ~pready;
    wire hit_ref = (paddr == OFF_CTRL_REF);
    wire hit_main = (paddr == OFF_CTRL_MAIN);
    wire hit_func = (paddr == OFF_CTRL_FUNC);
    wire hit_stat = (paddr == OFF_STATUS);
    wire hit_cfg = (paddr == OFF_CONFIG);
    wire mapped = hit_ref | hit_main | hit_func | hit_stat | hit_cfg;
    wire [31:0] status_word = {8'h00, load_count_q, 6'h00, last_addr_q,
                               5'h00, fast_acquire_out, powered_down, ce_sync};
    wire [31:0] rd_val = hit_ref ? {10'h000, ctrl_q[ADDR_REF]} :
                         hit_main ? {10'h000, ctrl_q[ADDR_MAIN]} :
                         hit_func ? {10'h000, ctrl_q[ADDR_FUNC]} :
                         hit_stat ? status_word :
                         hit_cfg ? config_q : 32'h00000000;

    // control words are read-only here, so software can never bypass the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            config_q <= CONFIG_RESET;
        end else begin
            pready <= access;
            if (access) begin
                pslverr <= ~mapped;
                prdata <= pwrite ? 32'h00000000 : rd_val;
            end
            if (access && pwrite && hit_cfg) begin
                config_q <= {31'h00000000, pwdata[SOFT_PWDN_BIT]};
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    AST_SHIFT_IN: assert property (@(posedge serial_clk) disable iff (!presetn) // RULE1
        shift_armed_q |->
        shift_q[0] == $past(serial_data) && shift_q[21:1] == $past(shift_q[20:0]))
        else $error("shift register did not take the data bit");
    AST_LOAD_WORD: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        load_ok |=> ctrl_q[$past(load_addr)] == $past(shift_q))
        else $error("strobe did not load the addressed register");
    AST_ADDR_THREE: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        (le_rise && load_addr == 2'h3) |=> load_count_q == $past(load_count_q))
        else $error("address three caused a load");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        !le_rise |=> $stable(ctrl_q[0]) && $stable(ctrl_q[1]) && $stable(ctrl_q[2]))
        else $error("control register changed without a strobe");
    AST_PWDN: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        (!chip_enable [*4]) |-> powered_down)
        else $error("chip enable low did not power down");
    AST_FA_MODE: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        (fa_ovr == FA_NORMAL) |=> fast_acquire_oen_n == !$past(fast_mode)
        && !fast_acquire_out)
        else $error("fast-acquire pin wrong in normal mode");
    AST_FA_OVR: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        (fa_ovr == FA_FORCE_HIGH) ##1 (fa_ovr == FA_FORCE_HIGH)
        |-> fast_acquire_out && !fast_acquire_oen_n)
        else $error("fast-acquire force high failed");
    AST_FA_Z: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        (fa_ovr == FA_FORCE_Z) |=> fast_acquire_oen_n)
        else $error("fast-acquire force high impedance failed");
    AST_STAT_DIG: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (stat_sel == STAT_DIG_LD) |=> multiplexed_status_out == $past(ld_dig_sync)
        && !multiplexed_status_oen_n)
        else $error("status pin does not show digital lock");
    AST_PRESC: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        load_ok && load_addr == ADDR_MAIN |-> ##2 prescaler_32 == $past(shift_q[PRESC_BIT], 2))
        else $error("prescaler select not applied");
    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable) |-> ##[0:1] pready)
        else $error("apb access not answered within one wait state");

    COV_LOAD_FUNC: cover property (@(posedge pclk) disable iff (!presetn)
        load_ok && load_addr == ADDR_FUNC);
    COV_FAST_ACTIVE: cover property (@(posedge pclk) disable iff (!presetn)
        !fast_acquire_oen_n && !fast_acquire_out);
    COV_PWDN: cover property (@(posedge pclk) disable iff (!presetn) $rose(powered_down));
    COV_APB_ERR: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule

// [tb/host_model.sv]
// host side of the three-wire programming link, driven through its tasks
// assumes: bench calls shift and load in turn; link clock only runs in frames
`timescale 1ns/1ps
module host_model (
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    // ****
    // link driving
    // ****
    // idle levels at time zero
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // msb first, 6 ns clock, odd start offset keeps it off the bus clock phase
    task automatic shift(input logic [21:0] w);
        #1.3;
        for (int i = 21; i >= 0; i--) begin
            serial_data = w[i];
            #3 serial_clk = 1'b1;
            #3 serial_clk = 1'b0;
        end
        serial_data = ~w[0]; // released line shows the inverse, not a stale bit
    endtask
    // strobe raised two bus clocks after the shift, held six bus clocks and followed by six more
    task automatic load();
        #100 load_strobe = 1'b1;
        #300 load_strobe = 1'b0;
        #300;
    endtask
endmodule

// [tb/tb_synth_serial_program_port.sv]
// self-checking bench of the serial programming port
// assumes: host_model drives the link; apb master here on pclk
`timescale 1ns/1ps
module tb_synth_serial_program_port;
    import synth_prog_pkg::*;
    logic pclk, pready, pslverr, err, serial_clk, serial_data, load_strobe;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chip_enable = 1'b1;
    logic ld_dig = 1'b0, ld_ana = 1'b0, ref_out = 1'b0, main_out = 1'b0;
    logic fa_out, fa_oen_n, st_out, st_oen_n, powered_down, prescaler_32;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [21:0] w, ref_w;
    int error_cnt = 0, compares = 0, cyc = 0;
    host_model u_host (.serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe));
    synth_serial_program_port #(.WORD_BITS(SHIFT_BITS)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe),
        .chip_enable(chip_enable), .lock_detect_dig(ld_dig), .lock_detect_ana(ld_ana),
        .ref_counter_out(ref_out), .main_counter_out(main_out), .fast_acquire_out(fa_out),
        .fast_acquire_oen_n(fa_oen_n), .multiplexed_status_out(st_out),
        .multiplexed_status_oen_n(st_oen_n), .powered_down(powered_down),
        .prescaler_32(prescaler_32));
    // ****
    // helpers
    // ****
    // 20 mhz bus clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // hang guard, far above the well under a thousand cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task end_of_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // request held until pready is sampled high, data taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic prog(input logic [21:0] v);
        u_host.shift(v);
        u_host.load();
    endtask
    // expected {oen_n, level}; level reads 0 while released
    function automatic logic [1:0] fa_exp(logic [1:0] ovr, logic mode);
        case (ovr)
            FA_NORMAL: return mode ? 2'b00 : 2'b10;
            FA_FORCE_LOW: return 2'b00;
            FA_FORCE_HIGH: return 2'b01;
            default: return 2'b10;
        endcase
    endfunction
    function automatic logic [1:0] st_exp(logic [2:0] sel);
        case (sel)
            STAT_DIG_LD: return {1'b0, ld_dig};
            STAT_ANA_LD: return ld_ana ? 2'b10 : 2'b00;
            STAT_REF_CNT: return {1'b0, ref_out};
            STAT_MAIN_CNT: return {1'b0, main_out};
            default: return 2'b00;
        endcase
    endfunction
    // ****
    // scenarios
    // ****
    initial begin
        rd = $urandom(65);
        repeat (2) @(posedge pclk);
        chk("pdn_rst", powered_down, 1'b1);
        chk("fa_rst", fa_oen_n, 1'b1);
        presetn <= 1'b1;
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk("config_rst", rd, CONFIG_RESET);
        // random words to every register address, main word drives the prescaler pin
        for (int k = 0; k < 12; k++) begin
            w = 22'($urandom);
            w[1:0] = 2'(k % 3);
            prog(w);
            apb(1'b0, 12'(w[1:0]) << 2, 32'h0);
            chk("word", rd, {10'h0, w});
            if (w[1:0] == ADDR_MAIN) chk("presc", prescaler_32, w[PRESC_BIT]);
        end
        // bits shifted without strobe must not reach the register
        ref_w = {20'($urandom), ADDR_REF};
        u_host.shift(ref_w);
        apb(1'b0, OFF_CTRL_REF, 32'h0);
        chk("no_strobe", rd[21:0] == ref_w, 1'b0);
        u_host.load();
        apb(1'b0, OFF_CTRL_REF, 32'h0);
        chk("strobe", rd, {10'h0, ref_w});
        prog({20'($urandom), 2'h3});
        apb(1'b0, OFF_CTRL_REF, 32'h0);
        chk("addr3", rd, {10'h0, ref_w});
        // every override code with fast mode off and on
        for (int m = 0; m < 8; m++) begin
            w = {20'($urandom), ADDR_FUNC};
            w[FA_OVR_LSB +: 2] = m[1:0];
            w[FAST_MODE_BIT] = m[2];
            prog(w);
            chk("fa_pin", {fa_oen_n, fa_oen_n ? 1'b0 : fa_out}, fa_exp(m[1:0], m[2]));
        end
        // every status selection with random lock and counter levels
        for (int s = 0; s < 12; s++) begin
            w = {20'($urandom), ADDR_FUNC};
            w[STAT_SEL_LSB +: 3] = 3'(s % 6);
            {ld_dig, ld_ana, ref_out, main_out} <= 4'($urandom);
            prog(w);
            chk("status", {st_oen_n, st_oen_n ? 1'b0 : st_out}, st_exp(3'(s % 6)));
        end
        // chip enable low, then the soft power-down bit
        chip_enable <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("pdn_ce", {rd[1:0], powered_down}, 3'b101);
        chip_enable <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("pdn_up", powered_down, 1'b0);
        apb(1'b1, OFF_CONFIG, 32'h1);
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk("pdn_soft", {rd, powered_down}, {32'h1, 1'b1});
        // unmapped address and a read-only register
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped", {err, rd}, {1'b1, 32'h0});
        apb(1'b1, OFF_CTRL_REF, 32'hffffffff);
        apb(1'b0, OFF_CTRL_REF, 32'h0);
        chk("read_only", {err, rd}, {1'b0, 10'h0, ref_w});
        // second reset in mid-run clears the control words
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CTRL_REF, 32'h0);
        chk("ref_rst2", rd, {10'h0, CTRL_RESET});
        end_of_test();
    end
endmodule
